// ==== design/ufbsp_pkg.sv ====
// Purpose: Shared constants for the fractional-baud serial port
// Assumes: 8-bit special-function register port, 25 MHz core clock
// Notes:   Offsets are the register port addresses
package ufbsp_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'he1;
   localparam logic [7:0] DATA_ADDR = 8'heb;
   localparam logic [7:0] BAUD_ADDR = 8'hee;
   // ----------------------------------------------------------------
   // Control/status bit positions
   // ----------------------------------------------------------------
   localparam int CTRL_NINE  = 6;
   localparam int CTRL_OVR   = 5;
   localparam int CTRL_FCHK  = 4;
   localparam int CTRL_BRK   = 3;
   localparam int CTRL_REN   = 2;
   localparam int CTRL_TDONE = 1;
   localparam int CTRL_RDONE = 0;
   // ----------------------------------------------------------------
   // Baud control bit positions
   // ----------------------------------------------------------------
   localparam int BAUD_TB8   = 7;
   localparam int BAUD_RB8   = 6;
   localparam int BAUD_FSEL  = 5;
   localparam int BAUD_EXT_H = 4;
   localparam int BAUD_EXT_L = 3;
   localparam int BAUD_DIV_H = 2;
   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [7:0] FRAC_SET   = 8'h2b;
   localparam logic [7:0] FRAC_CLR   = 8'h07;
   localparam logic [7:0] FRAC_ONE   = 8'h40;
   localparam logic [3:0] OVS_LAST   = 4'hf;
   localparam logic [3:0] OVS_MID    = 4'h7;
   localparam logic [7:0] BRK_TICKS  = 8'ha8;
   localparam logic [3:0] BITS_8     = 4'ha;
   localparam logic [3:0] BITS_9     = 4'hb;
   localparam int         FIFO_DEPTH = 32;
   localparam int         FIFO_WIDTH = 8;
endpackage

// ==== design/ufbsp_baud.sv ====
// Purpose: Baud timer giving a sixteen-times bit-rate tick
// Assumes: Configuration comes from registers on the same clock
// Notes:   Fraction done by an accumulator, so ticks jitter by one step
`timescale 1ns/10ps
`default_nettype none
module ufbsp_baud
   import ufbsp_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [2:0] binary_divider_code_in,
   input  wire logic [1:0] extended_divider_code_in,
   input  wire logic       fraction_select_in,
   output logic            tick16_out
);
   logic [9:0] pre_q, pre_d, limit;
   logic [7:0] acc_q, acc_d, frac, sum;
   logic       tick_q, tick_d, pre_tick;
   logic [3:0] shift_n;

   // ----------------------------------------------------------------
   // Integer and fractional division
   // ----------------------------------------------------------------
   always_comb begin
      shift_n  = {1'b0, binary_divider_code_in} + {2'b00, extended_divider_code_in};
      limit    = 10'((11'h001 << shift_n) - 11'h001);
      pre_tick = (pre_q >= limit);
      pre_d    = pre_tick ? 10'h000 : 10'(pre_q + 10'h001);
      frac     = fraction_select_in ? FRAC_SET : FRAC_CLR;
      sum      = 8'(acc_q + FRAC_ONE);
      acc_d    = acc_q;
      tick_d   = 1'b0;
      if (acc_q >= 8'(FRAC_ONE + frac)) begin
         // A fraction change can strand the phase above range; restart it
         acc_d = 8'h00;
      end else if (pre_tick) begin
         // Rate = pre_tick * 64 / (64 + fraction)
         if (sum >= 8'(FRAC_ONE + frac)) begin
            acc_d  = 8'(sum - FRAC_ONE - frac);
            tick_d = 1'b1;
         end else begin
            acc_d = sum;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_q  <= 10'h000;
         acc_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         acc_q  <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign tick16_out = tick_q;

   a_pre_every_cycle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (shift_n == 4'h0 && $past(shift_n) == 4'h0) |-> pre_tick)
      else $error("prescaler did not pass every cycle at code zero");
   a_acc_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $past(frac) == frac |-> acc_q < 8'(FRAC_ONE + frac))
      else $error("fraction accumulator out of range");
endmodule
`default_nettype wire

// ==== design/ufbsp_fifo.sv ====
// Purpose: Transmit byte FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Full and empty are registered
`timescale 1ns/10ps
`default_nettype none
module ufbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic [WIDTH-1:0]      out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             full_q, full_d, empty_q, empty_d, push, pop;

   always_comb begin
      push    = in_valid_in && !full_q;
      pop     = out_ready_in && !empty_q;
      wp_d    = push ? AW'(wp_q + 1'b1) : wp_q;
      rp_d    = pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_d   = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      full_d  = (cnt_d == (AW+1)'(DEPTH));
      empty_d = (cnt_d == '0);
   end

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wp_q    <= '0;
         rp_q    <= '0;
         cnt_q   <= '0;
         full_q  <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         wp_q    <= wp_d;
         rp_q    <= rp_d;
         cnt_q   <= cnt_d;
         full_q  <= full_d;
         empty_q <= empty_d;
      end
   end

   assign in_ready_out  = !full_q;
   assign out_valid_out = !empty_q;
   assign out_data_out  = mem_q[rp_q];

   a_fifo_count: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cnt_q <= (AW+1)'(DEPTH) && (full_q == (cnt_q == (AW+1)'(DEPTH))))
      else $error("fifo count and full flag disagree");
endmodule
`default_nettype wire

// ==== design/ufbsp_top.sv ====
// Purpose: Serial port with fractional baud timer and register port
// Assumes: Register port and extended enable are on sys_clk_in
// Notes:   Writes to the data buffer queue bytes; full queue drops writes
`timescale 1ns/10ps
`default_nettype none
module ufbsp_top
   import ufbsp_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic       sfr_wr_in,
   input  wire logic       sfr_rd_in,
   input  wire logic [7:0] sfr_wdata_in,
   input  wire logic       extended_uart_enable_in,
   input  wire logic       rx_line_in,
   output logic [7:0]      sfr_rdata_out,
   output logic            tx_line_out,
   output logic            frame_err_out,
   output logic            tx_space_out
);
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} ufbsp_tx_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
      RX_STOP = 5'b01000, RX_BRK = 5'b10000
   } ufbsp_rx_t;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d, baud_q, baud_d, rxbuf_q, rxbuf_d, rdata_q, rdata_d;
   logic       fe_q, fe_d;
   logic       wr_ctrl, wr_data, wr_baud, tick16;
   logic       fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;
   logic       nine, rx_en;

   assign wr_ctrl = sfr_wr_in && (sfr_addr_in == CTRL_ADDR);
   assign wr_data = sfr_wr_in && (sfr_addr_in == DATA_ADDR);
   assign wr_baud = sfr_wr_in && (sfr_addr_in == BAUD_ADDR);
   assign nine    = ctrl_q[CTRL_NINE];
   assign rx_en   = ctrl_q[CTRL_REN];

   // ----------------------------------------------------------------
   // Baud timer and transmit queue
   // ----------------------------------------------------------------
   ufbsp_baud u_baud (
      .sys_clk_in               (sys_clk_in),
      .rst_n_in                 (rst_n_in),
      .binary_divider_code_in   (baud_q[BAUD_DIV_H:0]),
      .extended_divider_code_in (baud_q[BAUD_EXT_H:BAUD_EXT_L]),
      .fraction_select_in       (baud_q[BAUD_FSEL]),
      .tick16_out               (tick16)
   );

   ufbsp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk_in    (sys_clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (wr_data),
      .in_data_in    (sfr_wdata_in),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out_data),
      .out_ready_in  (fifo_pop)
   );

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   ufbsp_tx_t  tx_st_q, tx_st_d;
   logic [10:0] tsh_q, tsh_d;
   logic [3:0]  tcnt_q, tcnt_d, tdiv_q, tdiv_d, tlen;
   logic        txl_q, txl_d, tx_set, tx_step;

   always_comb begin
      tx_st_d  = tx_st_q;
      tsh_d    = tsh_q;
      tcnt_d   = tcnt_q;
      tdiv_d   = tdiv_q;
      tx_set   = 1'b0;
      fifo_pop = 1'b0;
      tlen     = nine ? BITS_9 : BITS_8;
      tx_step  = tick16 && (tdiv_q == OVS_LAST);
      case (tx_st_q)
         TX_IDLE: begin
            if (fifo_out_valid) begin
               fifo_pop = 1'b1;
               // Stop sits right behind the data, or behind bit nine
               tsh_d    = nine ? {1'b1, baud_q[BAUD_TB8], fifo_out_data, 1'b0}
                               : {2'b11, fifo_out_data, 1'b0};
               tcnt_d   = 4'h0;
               tdiv_d   = 4'h0;
               tx_st_d  = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (tick16) begin
               tdiv_d = 4'(tdiv_q + 4'h1);
            end
            if (tx_step) begin
               tsh_d  = {1'b1, tsh_q[10:1]};
               tcnt_d = 4'(tcnt_q + 4'h1);
               tx_set = (4'(tcnt_q + 4'h2) == tlen);
               if (4'(tcnt_q + 4'h1) == tlen) begin
                  tx_st_d = TX_IDLE;
               end
            end
         end
         default: tx_st_d = TX_IDLE;
      endcase
      txl_d = (tx_st_d == TX_SHIFT) ? tsh_d[0] : 1'b1;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_st_q <= TX_IDLE;
         tsh_q   <= 11'h7ff;
         tcnt_q  <= 4'h0;
         tdiv_q  <= 4'h0;
         txl_q   <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tsh_q   <= tsh_d;
         tcnt_q  <= tcnt_d;
         tdiv_q  <= tdiv_d;
         txl_q   <= txl_d;
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   ufbsp_rx_t  rx_st_q, rx_st_d;
   logic       s1_q, s2_q, s3_q, fall;
   logic [8:0] rsh_q, rsh_d;
   logic [3:0] rtc_q, rtc_d, rbit_q, rbit_d, rlen;
   logic [7:0] low_q, low_d, rx_data;
   logic       brk_q, brk_d, rx_final, rx_accept, stop_ok;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= rx_line_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_comb begin
      fall      = s3_q && !s2_q;
      rx_st_d   = rx_st_q;
      rsh_d     = rsh_q;
      rtc_d     = rtc_q;
      rbit_d    = rbit_q;
      brk_d     = brk_q;
      rlen      = nine ? 4'h9 : 4'h8;
      rx_data   = nine ? rsh_q[7:0] : rsh_q[8:1];
      stop_ok   = s2_q;
      rx_final  = 1'b0;
      low_d     = low_q;
      if (tick16) begin
         low_d = s2_q ? 8'h00 : ((low_q == 8'hff) ? low_q : 8'(low_q + 8'h01));
      end
      if (tick16 && rx_st_q != RX_IDLE) begin
         rtc_d = 4'(rtc_q + 4'h1);
      end
      case (rx_st_q)
         RX_IDLE: begin
            if (rx_en && fall) begin
               rx_st_d = RX_START;
               rtc_d   = 4'h0;
               low_d   = 8'h00;
            end
         end
         RX_START: begin
            if (tick16 && rtc_q == OVS_MID) begin
               rtc_d   = 4'h0;
               rbit_d  = 4'h0;
               rx_st_d = s2_q ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (tick16 && rtc_q == OVS_LAST) begin
               rsh_d  = {s2_q, rsh_q[8:1]};
               rbit_d = 4'(rbit_q + 4'h1);
               if (4'(rbit_q + 4'h1) == rlen) begin
                  rx_st_d = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (tick16 && rtc_q == OVS_LAST) begin
               rx_final = 1'b1;
               if (stop_ok) begin
                  brk_d   = 1'b0;
                  rx_st_d = RX_IDLE;
               end else begin
                  rx_st_d = RX_BRK;
               end
            end
         end
         RX_BRK: begin
            // Waits for the line to rise so a stuck-low line is timed whole
            if (tick16 && s2_q) begin
               brk_d   = (low_q >= BRK_TICKS);
               rx_st_d = RX_IDLE;
            end
         end
         default: rx_st_d = RX_IDLE;
      endcase
      rx_accept = rx_final && (extended_uart_enable_in || !ctrl_q[CTRL_RDONE])
                  && (!ctrl_q[CTRL_FCHK] || stop_ok);
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_st_q <= RX_IDLE;
         rsh_q   <= 9'h000;
         rtc_q   <= 4'h0;
         rbit_q  <= 4'h0;
         low_q   <= 8'h00;
         brk_q   <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rsh_q   <= rsh_d;
         rtc_q   <= rtc_d;
         rbit_q  <= rbit_d;
         low_q   <= low_d;
         brk_q   <= brk_d;
      end
   end

   // ----------------------------------------------------------------
   // Register file; hardware set wins over a software clear
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_d  = ctrl_q;
      baud_d  = baud_q;
      rxbuf_d = rxbuf_q;
      fe_d    = fe_q;
      if (wr_ctrl) begin
         ctrl_d[CTRL_NINE]  = sfr_wdata_in[CTRL_NINE];
         ctrl_d[CTRL_FCHK]  = sfr_wdata_in[CTRL_FCHK];
         ctrl_d[CTRL_REN]   = sfr_wdata_in[CTRL_REN];
         ctrl_d[CTRL_TDONE] = sfr_wdata_in[CTRL_TDONE];
         ctrl_d[CTRL_RDONE] = sfr_wdata_in[CTRL_RDONE];
         ctrl_d[CTRL_OVR]   = ctrl_q[CTRL_OVR] && sfr_wdata_in[CTRL_OVR];
      end
      if (wr_baud) begin
         baud_d = {sfr_wdata_in[7], baud_q[BAUD_RB8], sfr_wdata_in[5:0]};
      end
      ctrl_d[7]        = 1'b0;
      ctrl_d[CTRL_BRK] = brk_q;
      if (tx_set) begin
         ctrl_d[CTRL_TDONE] = 1'b1;
      end
      if (rx_final && extended_uart_enable_in) begin
         fe_d = !stop_ok;
      end
      if (rx_accept) begin
         rxbuf_d            = rx_data;
         ctrl_d[CTRL_RDONE] = 1'b1;
         baud_d[BAUD_RB8]   = nine ? rsh_q[8] : stop_ok;
         if (ctrl_q[CTRL_RDONE]) begin
            ctrl_d[CTRL_OVR] = 1'b1;
         end
      end
      rdata_d = 8'h00;
      if (sfr_rd_in) begin
         if (sfr_addr_in == CTRL_ADDR) begin
            rdata_d = ctrl_q;
         end else if (sfr_addr_in == DATA_ADDR) begin
            rdata_d = rxbuf_q;
         end else if (sfr_addr_in == BAUD_ADDR) begin
            rdata_d = baud_q;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q  <= REG_RESET;
         baud_q  <= REG_RESET;
         rxbuf_q <= REG_RESET;
         rdata_q <= REG_RESET;
         fe_q    <= 1'b0;
         tx_space_out <= 1'b1;
      end else begin
         ctrl_q  <= ctrl_d;
         baud_q  <= baud_d;
         rxbuf_q <= rxbuf_d;
         rdata_q <= rdata_d;
         fe_q    <= fe_d;
         tx_space_out <= fifo_in_ready;
      end
   end

   assign sfr_rdata_out = rdata_q;
   assign tx_line_out   = txl_q;
   assign frame_err_out = fe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_tx_start_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (tx_st_q == TX_IDLE && fifo_out_valid) |=> !tx_line_out ##1 !tx_line_out)
      else $error("start bit not driven low");
   a_tx_done_stop: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(ctrl_q[CTRL_TDONE]) && !$past(wr_ctrl) |-> tx_line_out)
      else $error("transmit done set without stop bit on pin");
   a_rx_start_go: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_st_q == RX_IDLE && rx_en && fall) |=> rx_st_q == RX_START)
      else $error("start edge not taken");
   a_rx_no_overwrite: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_final && !extended_uart_enable_in && ctrl_q[CTRL_RDONE]) |-> !rx_accept)
      else $error("unread data overwritten");
   a_rx_stop_check: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_final && ctrl_q[CTRL_FCHK] && !stop_ok) |=> rxbuf_q == $past(rxbuf_q))
      else $error("frame with low stop accepted");
   a_rx_drop_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_final && !rx_accept && !ctrl_q[CTRL_RDONE] && !wr_ctrl) |=> !ctrl_q[CTRL_RDONE])
      else $error("dropped frame set receive done");
   a_rx_accept_buf: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rx_accept |=> ctrl_q[CTRL_RDONE] && rxbuf_q == $past(rx_data))
      else $error("accepted byte not in receive buffer");
   a_rx_overrun: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_accept && ctrl_q[CTRL_RDONE]) |=> ctrl_q[CTRL_OVR])
      else $error("overrun not flagged");
   a_rx_ninth_stop: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rx_accept && !nine) |=> baud_q[BAUD_RB8] == $past(s2_q))
      else $error("stop bit not latched in eight-bit mode");
endmodule
`default_nettype wire

// ==== verif/ufbsp_remote.sv ====
// Purpose: Remote serial device on the line side of the port
// Assumes: Divider code and fraction follow what the bench programs
// Notes:   Frames are sent on request; transmit line frames are decoded
`timescale 1ns/10ps
`default_nettype none
module ufbsp_remote #(
   parameter real CLK_NS = 40.0
) (
   input  wire logic       tx_line_in,
   input  wire logic [2:0] div_code_in,
   input  wire logic [7:0] frac_in,
   output var  logic       rx_line_out
);
   logic [8:0] got_q[$];
   logic [8:0] shf;
   real        bit_t;
   always_comb bit_t = CLK_NS * 16.0 * (1 << div_code_in) * (64.0 + frac_in) / 64.0;
   initial rx_line_out = 1'b1;
   task automatic send(input logic [10:0] frm, input int n);
      for (int i = 0; i < n; i++) begin
         rx_line_out = frm[i];
         #(bit_t);
      end
      rx_line_out = 1'b1;
   endtask
   // Mid-bit sampling tolerates the fractional jitter of the timer
   always begin
      @(negedge tx_line_in);
      #(bit_t / 2.0);
      for (int i = 0; i < 9; i++) begin
         #(bit_t);
         shf[i] = tx_line_in;
      end
      got_q.push_back(shf);
   end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the fractional-baud serial port
// Assumes: Remote is told the divider code and fraction the bench programs
// Notes:   Register tasks start just after a rising edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench
   import ufbsp_pkg::*;
;
   logic       sys_clk, rst_n, wr, rd, ext, rx_line, tx_line, frame_err, tx_space;
   logic [7:0] addr, wdata, rdata, frac;
   logic [2:0] div_code;
   int         n_errors, check_count, cyc;
   ufbsp_top i_dut (
      .sys_clk_in              (sys_clk),
      .rst_n_in                (rst_n),
      .sfr_addr_in             (addr),
      .sfr_wr_in               (wr),
      .sfr_rd_in               (rd),
      .sfr_wdata_in            (wdata),
      .extended_uart_enable_in (ext),
      .rx_line_in              (rx_line),
      .sfr_rdata_out           (rdata),
      .tx_line_out             (tx_line),
      .frame_err_out           (frame_err),
      .tx_space_out            (tx_space)
   );
   ufbsp_remote #(.CLK_NS(40.0)) i_remote (
      .tx_line_in  (tx_line),
      .div_code_in (div_code),
      .frac_in     (frac),
      .rx_line_out (rx_line)
   );
   always #20 sys_clk = ~sys_clk;
   // Over three times the expected run length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Strobe low for a full cycle so back-to-back calls never retime it
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge sys_clk);
      #1 wr = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(posedge sys_clk);
      #1 rd = 1'b0;
      `CHK(rdata, exp)
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_tx(input int n);
      for (int i = 0; i < 8000 && i_remote.got_q.size() < n; i++)
         @(posedge sys_clk);
      #1;
   endtask
   task automatic rx_frame(input logic [10:0] frm, input int n);
      i_remote.send(frm, n);
      // Room for the synchroniser, a late tick and the flag register
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {addr, wdata, wr, rd, ext, div_code} = '0;
      frac = FRAC_CLR;
      repeat (20) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      rd_chk(CTRL_ADDR, REG_RESET);
      rd_chk(BAUD_ADDR, REG_RESET);
      rd_chk(DATA_ADDR, REG_RESET);
      rd_chk(8'h00, 8'h00);
      wr_reg(BAUD_ADDR, 8'hc0);
      rd_chk(BAUD_ADDR, 8'h80);
      wr_reg(BAUD_ADDR, 8'h00);
      // One byte goes straight to the shifter, 32 fill the queue, one drops
      for (int i = 0; i < 34; i++)
         wr_reg(DATA_ADDR, 8'(i * 37));
      `CHK(tx_space, 1'b0)
      wait_tx(33);
      repeat (400) @(posedge sys_clk);
      `CHK(i_remote.got_q.size(), 33)
      for (int i = 0; i < 33; i++)
         `CHK(i_remote.got_q[i], {1'b1, 8'(i * 37)})
      rd_chk(CTRL_ADDR, 8'h02);
      i_remote.got_q.delete();
      wr_reg(BAUD_ADDR, 8'h01);
      div_code = 3'h1;
      wr_reg(DATA_ADDR, 8'h96);
      wait_tx(1);
      `CHK(i_remote.got_q[0], 9'h196)
      wr_reg(BAUD_ADDR, 8'h28);
      frac = FRAC_SET;
      wr_reg(DATA_ADDR, 8'ha5);
      wait_tx(2);
      `CHK(i_remote.got_q[1], 9'h1a5)
      wr_reg(BAUD_ADDR, 8'h00);
      div_code = 3'h0;
      frac = FRAC_CLR;
      wr_reg(CTRL_ADDR, 8'h04);
      rx_frame({2'b01, 8'h3c, 1'b0}, 10);
      rd_chk(DATA_ADDR, 8'h3c);
      rd_chk(CTRL_ADDR, 8'h05);
      rd_chk(BAUD_ADDR, 8'h40);
      rx_frame({2'b01, 8'h99, 1'b0}, 10);
      rd_chk(DATA_ADDR, 8'h3c);
      rd_chk(CTRL_ADDR, 8'h05);
      ext = 1'b1;
      rx_frame({2'b01, 8'h5a, 1'b0}, 10);
      rd_chk(DATA_ADDR, 8'h5a);
      rd_chk(CTRL_ADDR, 8'h25);
      wr_reg(CTRL_ADDR, 8'h14);
      rd_chk(CTRL_ADDR, 8'h14);
      rx_frame({2'b00, 8'h81, 1'b0}, 10);
      `CHK(frame_err, 1'b1)
      rd_chk(CTRL_ADDR, 8'h14);
      rd_chk(DATA_ADDR, 8'h5a);
      rx_frame({2'b01, 8'h7e, 1'b0}, 10);
      `CHK(frame_err, 1'b0)
      rd_chk(DATA_ADDR, 8'h7e);
      wr_reg(CTRL_ADDR, 8'h44);
      rx_frame({1'b1, 1'b0, 8'hc3, 1'b0}, 11);
      rd_chk(DATA_ADDR, 8'hc3);
      rd_chk(BAUD_ADDR, 8'h00);
      wr_reg(CTRL_ADDR, 8'h14);
      rx_frame(11'h000, 11);
      rd_chk(CTRL_ADDR, 8'h1c);
      rx_frame({2'b01, 8'h3c, 1'b0}, 10);
      rd_chk(CTRL_ADDR, 8'h15);
      wr_reg(CTRL_ADDR, 8'h40);
      i_remote.got_q.delete();
      wr_reg(DATA_ADDR, 8'h3c);
      wait_tx(1);
      `CHK(i_remote.got_q[0], 9'h03c)
      complete_run();
   end
endmodule
`default_nettype wire
